// ---- hw/rqqa_arbiter.sv ----
// read qos queue arbiter: queue entries, qos timeouts, refresh timeout, bank scheduling,
// apb register slave. assumes hazard logic upstream supplies dependency masks and the
// command fifo downstream signals cmd_ready_i; everything runs on sys_clk_i.
//
// Our own choices: register access over APB and the placing of the registers.
`default_nettype none
module rqqa_arbiter
  import rqqa_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              data_valid_i,
  output logic                   data_ready_o,
  input  wire logic              data_is_read_i,
  input  wire logic [ID_W-1:0]   data_id_i,
  input  wire logic [BANK_W-1:0] data_bank_i,
  input  wire logic [ROW_W-1:0]  data_row_i,
  input  wire logic [QN-1:0]     data_dep_i,
  input  wire logic [15:0]       qos_override_i,
  input  wire logic              mgmt_valid_i,
  output logic                   mgmt_ready_o,
  output logic                   cmd_valid_o,
  input  wire logic              cmd_ready_i,
  output rqqa_cmd_t              cmd_type_o,
  output logic      [BANK_W-1:0] cmd_bank_o,
  output logic      [ROW_W-1:0]  cmd_row_o,
  output logic      [2:0]        cmd_entry_o
);

  typedef struct packed {
    rqqa_entry_t [QN-1:0]   ent;
    rqqa_bank_t  [NB-1:0]   bank;
    rqqa_qcfg_t  [NCFG-1:0] cfg;
    logic [2:0]             qsel;
    logic [CNT_W-1:0]       max_refs;
    logic [7:0]             rcd;
    logic [7:0]             rp;
    logic [CNT_W-1:0]       ref_cnt;
    logic                   ref_to;
    logic                   last_prep;
    logic                   last_rd;
    logic                   cmd_valid;
    rqqa_cmd_t              cmd_type;
    logic [BANK_W-1:0]      cmd_bank;
    logic [ROW_W-1:0]       cmd_row;
    logic [2:0]             cmd_entry;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } rqqa_state_t;

  rqqa_state_t q;
  rqqa_state_t d;

  logic [QN-1:0] vld;
  logic [QN-1:0] hit;
  logic [QN-1:0] rdy;
  logic [QN-1:0] tmin;
  logic [QN-1:0] tmax;
  logic [QN-1:0] rdmask;

  // one-hot pick of the entry in s that has no earlier entry also in s
  function automatic logic [QN-1:0] pick_oldest(input logic [QN-1:0] s,
                                                input rqqa_entry_t [QN-1:0] e);
    logic [QN-1:0] r;
    r = '0;
    for (int i = 0; i < QN; i++) begin
      if (s[i] && !(|(s & e[i].older))) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // lowest free slot; the queue fills from slot zero upward
  function automatic logic [QN-1:0] first_free(input logic [QN-1:0] v);
    logic [QN-1:0] r;
    logic          found;
    r = '0;
    found = 1'b0;
    for (int i = 0; i < QN; i++) begin
      if (!v[i] && !found) begin
        r[i] = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // per-entry classification from the current row cache
  // a refresh never counts as a hit, so it stays in the manager class
  always_comb begin
    for (int i = 0; i < QN; i++) begin
      vld[i]    = q.ent[i].vld;
      rdmask[i] = q.ent[i].rd;
      hit[i]    = q.ent[i].vld && !q.ent[i].rf && q.bank[q.ent[i].bank].open
                  && (q.bank[q.ent[i].bank].row == q.ent[i].row);
      rdy[i]    = q.ent[i].vld && (q.ent[i].dep == '0)
                  && (q.ent[i].rf || q.bank[q.ent[i].bank].timer == 8'h00);
      tmin[i]   = q.ent[i].vld && q.ent[i].qmin;
      tmax[i]   = q.ent[i].vld && (q.ent[i].fto
                  || (q.ent[i].qen && q.ent[i].qmax == 8'h00)
                  || (q.ent[i].rf && q.ref_to));
    end
  end

  logic [QN-1:0]     hset;
  logic [QN-1:0]     pset;
  logic [QN-1:0]     mset;
  logic [QN-1:0]     hpick;
  logic [QN-1:0]     gnt;
  logic [QN-1:0]     slot;
  logic              fire;
  logic [2:0]        gidx;
  logic [2:0]        sidx;
  logic [3:0]        qidx;
  rqqa_qcfg_t        qc;
  rqqa_entry_t       ge;
  logic              mk_mgmt;
  logic              mk_data;
  logic              ref_done;
  logic [11:0]       cfg_off;

  always_comb begin
    d = q;
    // sets of available candidates per class
    hset = rdy & hit;
    pset = rdy & ~hit & ~mset_mask(q.ent);
    mset = rdy & mset_mask(q.ent);
    // same-direction hits first, then any hit
    if (|(hset & (q.last_rd ? rdmask : ~rdmask))) begin
      hpick = pick_oldest(hset & (q.last_rd ? rdmask : ~rdmask), q.ent);
    end else begin
      hpick = pick_oldest(hset, q.ent);
    end
    if (|(rdy & tmin)) begin
      gnt = pick_oldest(rdy & tmin, q.ent);
    end else if (|(rdy & tmax)) begin
      gnt = pick_oldest(rdy & tmax, q.ent);
    end else if (q.last_prep && |hset) begin
      gnt = hpick;
    end else if (|pset) begin
      gnt = pick_oldest(pset, q.ent);
    end else if (|hset) begin
      gnt = hpick;
    end else begin
      gnt = pick_oldest(mset, q.ent);
    end
    // a held command blocks new grants; entry and bank timers keep counting
    fire = (|gnt) && (!q.cmd_valid || cmd_ready_i);
    gidx = '0;
    for (int i = 0; i < QN; i++) begin
      if (gnt[i]) begin
        gidx = 3'(i);
      end
    end
    ge = q.ent[gidx];

    // bank delays count down; entry timers and forced timeouts
    for (int b = 0; b < NB; b++) begin
      if (q.bank[b].timer != 8'h00) begin
        d.bank[b].timer = q.bank[b].timer - 8'h01;
      end
    end
    for (int i = 0; i < QN; i++) begin
      if (q.ent[i].vld && q.ent[i].qen && q.ent[i].qmax != 8'h00) begin
        d.ent[i].qmax = q.ent[i].qmax - 8'h01;
      end
      // a forced timeout stays until the entry leaves; a new entry starts clean
      for (int j = 0; j < QN; j++) begin
        if ((tmin[i] || tmax[i]) && q.ent[i].dep[j] && q.ent[j].vld) begin
          d.ent[j].fto = 1'b1;
        end
      end
    end

    if (!q.cmd_valid || cmd_ready_i) begin
      d.cmd_valid = 1'b0;
    end
    ref_done = 1'b0;
    if (fire) begin
      d.cmd_valid = 1'b1;
      d.cmd_bank  = ge.bank;
      d.cmd_row   = ge.row;
      // the slot index goes out with every command so prep and access can be paired
      d.cmd_entry = gidx;
      if (ge.rf) begin
        d.cmd_type = RQQA_CMD_REF;
        ref_done   = 1'b1;
      end else if (hit[gidx]) begin
        d.cmd_type  = ge.rd ? RQQA_CMD_RD : RQQA_CMD_WR;
        d.last_prep = 1'b0;
        d.last_rd   = ge.rd;
      end else begin
        d.last_prep = 1'b1;
        if (q.bank[ge.bank].open) begin
          d.cmd_type             = RQQA_CMD_PRE;
          d.bank[ge.bank].open  = 1'b0;
          d.bank[ge.bank].timer = q.rp;
        end else begin
          d.cmd_type             = RQQA_CMD_ACT;
          d.bank[ge.bank].open  = 1'b1;
          d.bank[ge.bank].row   = ge.row;
          d.bank[ge.bank].timer = q.rcd;
        end
      end
      // a preparation keeps its slot; data and refresh leave the queue
      if (ge.rf || hit[gidx]) begin
        d.ent[gidx].vld = 1'b0;
        for (int k = 0; k < QN; k++) begin
          d.ent[k].dep[gidx] = 1'b0;
        end
      end
    end

    // creation: management first, data waits while mgmt_valid_i is high
    // a slot freed by this cycle's grant is reused only from the next cycle
    slot    = first_free(vld);
    sidx    = '0;
    for (int i = 0; i < QN; i++) begin
      if (slot[i]) begin
        sidx = 3'(i);
      end
    end
    mk_mgmt = mgmt_valid_i && (|slot);
    mk_data = data_valid_i && (|slot) && !mgmt_valid_i;
    qidx    = data_id_i[q.qsel +: 4];
    qc      = q.cfg[qidx];
    if (mk_mgmt || mk_data) begin
      d.ent[sidx].vld   = 1'b1;
      d.ent[sidx].rf    = mk_mgmt;
      d.ent[sidx].rd    = mk_data && data_is_read_i;
      d.ent[sidx].fto   = 1'b0;
      d.ent[sidx].qen   = mk_data && data_is_read_i && qc.en;
      d.ent[sidx].qmin  = mk_data && data_is_read_i
                          && (qos_override_i[qidx] || (qc.en && qc.min));
      d.ent[sidx].qmax  = qc.max;
      d.ent[sidx].bank  = mk_data ? data_bank_i : '0;
      d.ent[sidx].row   = mk_data ? data_row_i : '0;
      // a dependency on an entry that leaves now would never be cleared; a
      // preparation grant keeps its slot, so that dependency must stay
      if (mk_data) begin
        d.ent[sidx].dep = data_dep_i & vld
                          & ~((fire && (ge.rf || hit[gidx])) ? gnt : '0);
      end else begin
        d.ent[sidx].dep = '0;
      end
      d.ent[sidx].older = vld;
      for (int k = 0; k < QN; k++) begin
        d.ent[k].older[sidx] = 1'b0;
      end
    end

    // refresh occupancy and sticky timeout; a set beats the clear
    d.ref_cnt = q.ref_cnt + CNT_W'(mk_mgmt) - CNT_W'(ref_done);
    if (q.max_refs != '0 && d.ref_cnt >= q.max_refs) begin
      d.ref_to = 1'b1;
    end else if (d.ref_cnt == '0) begin
      d.ref_to = 1'b0;
    end

    // apb: decode at setup, answer with pready in the access cycle
    // writes land at the access edge, so a read straight after sees the new value
    cfg_off = paddr_i - RQQA_OFF_QCFG;
    if (psel_i && !penable_i) begin
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      d.prdata  = '0;
      if (paddr_i == RQQA_OFF_CTRL) begin
        d.prdata[RQQA_QSEL_LSB +: 3] = q.qsel;
      end else if (paddr_i == RQQA_OFF_REFS) begin
        d.prdata[CNT_W-1:0] = q.max_refs;
      end else if (paddr_i == RQQA_OFF_SCHED) begin
        d.prdata[RQQA_RCD_LSB +: 8] = q.rcd;
        d.prdata[RQQA_RP_LSB +: 8]  = q.rp;
      end else if (paddr_i == RQQA_OFF_STATUS) begin
        d.prdata[RQQA_ST_TO_BIT]            = q.ref_to;
        d.prdata[RQQA_ST_CNT_LSB +: CNT_W]  = q.ref_cnt;
        d.prdata[RQQA_ST_VLD_LSB +: QN]     = vld;
      end else if (paddr_i >= RQQA_OFF_QCFG && cfg_off < 12'h040 && cfg_off[1:0] == 2'h0) begin
        d.prdata[RQQA_QEN_BIT]      = q.cfg[cfg_off[5:2]].en;
        d.prdata[RQQA_QMIN_BIT]     = q.cfg[cfg_off[5:2]].min;
        d.prdata[RQQA_QMAX_LSB +: 8] = q.cfg[cfg_off[5:2]].max;
      end else begin
        d.pslverr = 1'b1;
      end
    end else if (psel_i && penable_i && q.pready) begin
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      if (pwrite_i && !q.pslverr) begin
        if (paddr_i == RQQA_OFF_CTRL) begin
          d.qsel = pwdata_i[RQQA_QSEL_LSB +: 3];
        end else if (paddr_i == RQQA_OFF_REFS) begin
          d.max_refs = pwdata_i[CNT_W-1:0];
        end else if (paddr_i == RQQA_OFF_SCHED) begin
          d.rcd = pwdata_i[RQQA_RCD_LSB +: 8];
          d.rp  = pwdata_i[RQQA_RP_LSB +: 8];
        end else if (paddr_i != RQQA_OFF_STATUS) begin
          d.cfg[cfg_off[5:2]].en  = pwdata_i[RQQA_QEN_BIT];
          d.cfg[cfg_off[5:2]].min = pwdata_i[RQQA_QMIN_BIT];
          d.cfg[cfg_off[5:2]].max = pwdata_i[RQQA_QMAX_LSB +: 8];
        end
      end
    end else begin
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
    end
  end

  // manager entries are the refreshes; used by the grant logic above
  function automatic logic [QN-1:0] mset_mask(input rqqa_entry_t [QN-1:0] e);
    logic [QN-1:0] r;
    for (int i = 0; i < QN; i++) begin
      r[i] = e[i].rf;
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      // the blanket clear comes first; the register reset values and the idle command type follow it
      q          <= '0;
      q.qsel     <= RQQA_RST_QSEL;
      q.max_refs <= RQQA_RST_REFS;
      q.rcd      <= RQQA_RST_RCD;
      q.rp       <= RQQA_RST_RP;
      q.cmd_type <= RQQA_CMD_PRE;
    end else begin
      q <= d;
    end
  end

  assign prdata_o     = q.prdata;
  assign pready_o     = q.pready;
  assign pslverr_o    = q.pslverr && q.pready;
  assign data_ready_o = (|first_free(vld)) && !mgmt_valid_i;
  assign mgmt_ready_o = |first_free(vld);
  assign cmd_valid_o  = q.cmd_valid;
  assign cmd_type_o   = q.cmd_type;
  assign cmd_bank_o   = q.cmd_bank;
  assign cmd_row_o    = q.cmd_row;
  assign cmd_entry_o  = q.cmd_entry;

endmodule
`default_nettype wire

// ---- hw/rqqa_pkg.sv ----
// package of the read qos queue arbiter: sizes, register map, reset values, types
// assumes an apb master on the same clock and a command fifo that takes one command per cycle
`default_nettype none
package rqqa_pkg;
  localparam int QN      = 8;   // queue entries
  localparam int NB      = 4;   // banks tracked by the row cache
  localparam int ROW_W   = 13;
  localparam int ID_W    = 12;
  localparam int CNT_W   = 4;
  localparam int BANK_W  = 2;
  localparam int NCFG    = 16;

  localparam logic [11:0] RQQA_OFF_CTRL   = 12'h000;
  localparam logic [11:0] RQQA_OFF_REFS   = 12'h004;
  localparam logic [11:0] RQQA_OFF_SCHED  = 12'h008;
  localparam logic [11:0] RQQA_OFF_STATUS = 12'h00c;
  localparam logic [11:0] RQQA_OFF_QCFG   = 12'h040;  // sixteen words up to 0x07c

  localparam int RQQA_QSEL_LSB   = 0;
  localparam int RQQA_RCD_LSB    = 0;
  localparam int RQQA_RP_LSB     = 8;
  localparam int RQQA_QEN_BIT    = 0;
  localparam int RQQA_QMIN_BIT   = 1;
  localparam int RQQA_QMAX_LSB   = 8;
  localparam int RQQA_ST_TO_BIT  = 0;
  localparam int RQQA_ST_CNT_LSB = 8;
  localparam int RQQA_ST_VLD_LSB = 16;

  localparam logic [2:0]       RQQA_RST_QSEL = 3'h0;
  localparam logic [CNT_W-1:0] RQQA_RST_REFS = 4'h8;
  localparam logic [7:0]       RQQA_RST_RCD  = 8'h01;
  localparam logic [7:0]       RQQA_RST_RP   = 8'h01;

  typedef enum logic [2:0] {
    RQQA_CMD_PRE = 3'h0,
    RQQA_CMD_ACT = 3'h1,
    RQQA_CMD_RD  = 3'h3,
    RQQA_CMD_WR  = 3'h2,
    RQQA_CMD_REF = 3'h6
  } rqqa_cmd_t;

  typedef struct packed {
    logic              vld;
    logic              rd;
    logic              rf;     // manager (refresh) entry
    logic              qmin;
    logic              qen;
    logic              fto;    // timeout forced by a dependent entry
    logic [7:0]        qmax;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [QN-1:0]     dep;
    logic [QN-1:0]     older;  // bit j: entry j arrived earlier
  } rqqa_entry_t;

  typedef struct packed {
    logic             open;
    logic [ROW_W-1:0] row;
    logic [7:0]       timer;
  } rqqa_bank_t;

  typedef struct packed {
    logic       en;
    logic       min;
    logic [7:0] max;
  } rqqa_qcfg_t;
endpackage
`default_nettype wire

// ---- verification/rqqa_arbiter_chk.sv ----
// checker for the read qos queue arbiter: apb timing, command hold, entry admission
// assumes it is bound to rqqa_arbiter and sees only that module's ports
`default_nettype none
module rqqa_arbiter_chk
  import rqqa_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic [11:0]       paddr_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              data_valid_i,
  input wire logic              data_ready_o,
  input wire logic              mgmt_valid_i,
  input wire logic              mgmt_ready_o,
  input wire logic              cmd_valid_o,
  input wire logic              cmd_ready_i,
  input wire rqqa_cmd_t         cmd_type_o,
  input wire logic [BANK_W-1:0] cmd_bank_o,
  input wire logic [ROW_W-1:0]  cmd_row_o,
  input wire logic [2:0]        cmd_entry_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mapped;
  // aligned words only; the antecedent below filters on the low address bits
  assign mapped = (paddr_i[11:4] == 8'h00) || (paddr_i[11:6] == 6'h01);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence apb_setup; psel_i && !penable_i; endsequence
  sequence cmd_stall; cmd_valid_o && !cmd_ready_i; endsequence
  sequence data_taken; data_valid_i && data_ready_o; endsequence

  apb_zero_wait_a: assert property (apb_setup |=> pready_o && penable_i)
    else $error("ready missing after setup");
  ready_in_access_a: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("ready outside first access cycle");
  err_decode_a: assert property (pready_o && paddr_i[1:0] == 2'h0 |-> pslverr_o == !mapped)
    else $error("error response does not match address decode");
  cmd_held_a: assert property (cmd_stall |=> cmd_valid_o &&
    $stable({cmd_type_o, cmd_bank_o, cmd_row_o, cmd_entry_o})) else $error("command dropped");
  mgmt_wins_a: assert property (mgmt_valid_i |-> !data_ready_o)
    else $error("data entry taken beside management entry");
  cmd_legal_a: assert property (cmd_valid_o |-> cmd_type_o inside
    {RQQA_CMD_PRE, RQQA_CMD_ACT, RQQA_CMD_RD, RQQA_CMD_WR, RQQA_CMD_REF})
    else $error("illegal command code");
  entry_served_a: assert property (data_taken |-> ##[1:300] cmd_valid_o)
    else $error("queued entry never arbitrated");
  reset_quiet_a: assert property (@(posedge sys_clk_i) disable iff (1'b0)
    !rst_n_i |=> !cmd_valid_o && !pready_o && mgmt_ready_o) else $error("reset state wrong");
  stall_seen_c: cover property (cmd_stall);
endmodule
bind rqqa_arbiter rqqa_arbiter_chk i_chk (.sys_clk_i, .rst_n_i, .psel_i, .penable_i,
  .paddr_i, .pready_o, .pslverr_o, .data_valid_i, .data_ready_o, .mgmt_valid_i,
  .mgmt_ready_o, .cmd_valid_o, .cmd_ready_i, .cmd_type_o, .cmd_bank_o, .cmd_row_o,
  .cmd_entry_o);
`default_nettype wire

// ---- verification/rqqa_cmd_sink.sv ----
// model of the command fifo below the arbiter: accepts at once, slowly, or not at all
// assumes the bench steers hold_i and slow_i right after rising edges
`default_nettype none
module rqqa_cmd_sink (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic hold_i,
  input  wire logic slow_i,
  input  wire logic cmd_valid_i,
  output logic      cmd_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // slow mode takes one command every other cycle, like a nearly full fifo
  always @(posedge clk_i) begin
    if (!rst_n_i) cmd_ready_o <= 1'h0;
    else cmd_ready_o <= !hold_i && (!slow_i || !cmd_ready_o);
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for rqqa_arbiter: apb register access, row handling, qos, refresh
// assumes the checker is bound in separately and the command sink model is compiled
`default_nettype none
`define CHK(g, e, m) begin n_compared++; if (((g) & (m)) !== ((e) & (m))) begin \
  fail_count++; $display("mismatch at %0t got %h exp %h", $time, (g) & (m), (e) & (m)); end end
module tb
  import rqqa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic data_valid_i = 1'h0, data_is_read_i = 1'h0, mgmt_valid_i = 1'h0;
  logic hold = 1'h0, slow = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, data_ready_o, mgmt_ready_o, cmd_valid_o, cmd_ready_i;
  logic [ID_W-1:0] data_id_i = '0;
  logic [BANK_W-1:0] data_bank_i = '0, cmd_bank_o;
  logic [ROW_W-1:0] data_row_i = '0, cmd_row_o, r, r2, w;
  logic [QN-1:0] data_dep_i = '0;
  logic [15:0] qos_override_i = '0;
  logic [2:0] cmd_entry_o;
  rqqa_cmd_t cmd_type_o;
  int fail_count = 0, n_compared = 0, seed = 87795;
  logic [32:0] rq[$], rm[$];
  logic [20:0] cq[$], cm[$];

  rqqa_arbiter i_dut (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .psel_i         (psel_i),
    .penable_i      (penable_i),
    .pwrite_i       (pwrite_i),
    .paddr_i        (paddr_i),
    .pwdata_i       (pwdata_i),
    .prdata_o       (prdata_o),
    .pready_o       (pready_o),
    .pslverr_o      (pslverr_o),
    .data_valid_i   (data_valid_i),
    .data_ready_o   (data_ready_o),
    .data_is_read_i (data_is_read_i),
    .data_id_i      (data_id_i),
    .data_bank_i    (data_bank_i),
    .data_row_i     (data_row_i),
    .data_dep_i     (data_dep_i),
    .qos_override_i (qos_override_i),
    .mgmt_valid_i   (mgmt_valid_i),
    .mgmt_ready_o   (mgmt_ready_o),
    .cmd_valid_o    (cmd_valid_o),
    .cmd_ready_i    (cmd_ready_i),
    .cmd_type_o     (cmd_type_o),
    .cmd_bank_o     (cmd_bank_o),
    .cmd_row_o      (cmd_row_o),
    .cmd_entry_o    (cmd_entry_o)
  );
  rqqa_cmd_sink i_sink (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hold_i(hold), .slow_i(slow),
    .cmd_valid_i(cmd_valid_o), .cmd_ready_o(cmd_ready_i));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin : mon
    logic [32:0] e, m;
    logic [20:0] ce, cmk;
    if (psel_i && penable_i && pready_o && !pwrite_i && rq.size() > 0) begin
      e = rq.pop_front();
      m = rm.pop_front();
      `CHK({pslverr_o, prdata_o}, e, m)
    end
    if (cmd_valid_o && cmd_ready_i) begin
      ce = cq.size() > 0 ? cq.pop_front() : 21'h1fffff;
      cmk = cm.size() > 0 ? cm.pop_front() : 21'h1fffff;
      `CHK({cmd_entry_o, cmd_type_o, cmd_bank_o, cmd_row_o}, ce, cmk)
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d,
                     input logic [32:0] m);
    if (!w) begin
      rq.push_back(d);
      rm.push_back(m);
    end
    @(posedge sys_clk_i);
    psel_i <= 1'h1; penable_i <= 1'h0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d[31:0];
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    @(posedge sys_clk_i iff pready_o);
    psel_i <= 1'h0; penable_i <= 1'h0;
  endtask

  task automatic ex(input rqqa_cmd_t t, input logic [1:0] b, input logic [12:0] rw,
                    input logic [17:0] m, input logic [2:0] e = 3'h0,
                    input logic [2:0] em = 3'h7);
    cq.push_back({e, t, b, rw});
    cm.push_back({em, m});
  endtask

  task automatic put(input logic rd, input logic [11:0] id, input logic [1:0] b,
                     input logic [12:0] rw, input logic [15:0] o,
                     input logic [7:0] dp = 8'h00);
    @(posedge sys_clk_i);
    data_valid_i <= 1'h1; data_is_read_i <= rd; data_id_i <= id;
    data_bank_i <= b; data_row_i <= rw; qos_override_i <= o; data_dep_i <= dp;
    @(posedge sys_clk_i iff data_ready_o);
    data_valid_i <= 1'h0; data_row_i <= ~rw; qos_override_i <= ~o; data_dep_i <= 8'h00;
  endtask

  task automatic ref1();
    ex(RQQA_CMD_REF, 2'h0, 13'h0, 18'h38000, 3'h0, 3'h0);
    @(posedge sys_clk_i);
    mgmt_valid_i <= 1'h1;
    @(posedge sys_clk_i iff mgmt_ready_o);
    mgmt_valid_i <= 1'h0;
  endtask

  task automatic drain(input string s);
    for (int i = 0; i < 400 && cq.size() > 0; i++) @(posedge sys_clk_i);
    repeat (8) @(posedge sys_clk_i);
    `CHK(cq.size(), 0, 32'hffffffff)
    $display("test %s done", s);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #(40000 * 50);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    apb(1'h0, RQQA_OFF_REFS, 33'h8, '1);
    apb(1'h0, RQQA_OFF_SCHED, 33'h0101, '1);
    apb(1'h0, RQQA_OFF_QCFG + 12'h018, 33'h0, '1);
    apb(1'h0, 12'h020, 33'h100000000, '1);
    apb(1'h1, RQQA_OFF_CTRL, 33'h2, '0);
    apb(1'h1, RQQA_OFF_STATUS, 33'hffffffff, '0);
    apb(1'h0, RQQA_OFF_CTRL, 33'h2, '1);
    apb(1'h0, RQQA_OFF_STATUS, 33'h0, '1);
    $display("test regs done");
    // each bank: closed row, hit to the open row, then a conflicting row
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      r = $random(seed);
      r2 = r ^ 13'h1;
      ex(RQQA_CMD_ACT, k[1:0], r, '1);
      ex(RQQA_CMD_RD, k[1:0], r, '1);
      put(1'h1, $random(seed), k[1:0], r, 16'h0);
      drain("closed");
      ex(RQQA_CMD_WR, k[1:0], r, '1);
      put(1'h0, $random(seed), k[1:0], r, 16'h0);
      drain("hit");
      ex(RQQA_CMD_PRE, k[1:0], 13'h0, 18'h3e000);
      ex(RQQA_CMD_ACT, k[1:0], r2, '1);
      ex(RQQA_CMD_RD, k[1:0], r2, '1);
      put(1'h1, $random(seed), k[1:0], r2, 16'h0);
      drain("conflict");
    end
    // id 0x05a under select code 2 is index 6: pass 0 override, pass 1 max latency 3,
    // pass 2 override on a read that depends on the write, so the write goes first
    slow <= 1'h0;
    for (int p = 0; p < 3; p++) begin
      if (p == 1) begin
        apb(1'h1, RQQA_OFF_QCFG + 12'h018, 33'h0301, '0);
        apb(1'h0, RQQA_OFF_QCFG + 12'h018, 33'h0301, '1);
      end
      w = p[0] ? r2 : ~r2;
      hold <= 1'h1;
      ref1();
      if (p != 2) ex(RQQA_CMD_RD, 2'h3, r2, '1, 3'h1);
      ex(RQQA_CMD_PRE, 2'h2, 13'h0, 18'h3e000);
      ex(RQQA_CMD_ACT, 2'h2, w, '1);
      ex(RQQA_CMD_WR, 2'h2, w, '1);
      if (p == 2) ex(RQQA_CMD_RD, 2'h3, r2, '1, 3'h1);
      put(1'h0, 12'h05a, 2'h2, w, 16'h0040);
      put(1'h1, 12'h05a, 2'h3, r2, p == 1 ? 16'h0 : 16'h0040, p == 2 ? 8'h01 : 8'h00);
      repeat (4) @(posedge sys_clk_i);
      hold <= 1'h0;
      drain("qos");
    end
    apb(1'h1, RQQA_OFF_REFS, 33'h2, '0);
    hold <= 1'h1;
    repeat (3) ref1();
    apb(1'h0, RQQA_OFF_STATUS, 33'h1, 33'h1);
    hold <= 1'h0;
    drain("refresh");
    apb(1'h0, RQQA_OFF_STATUS, 33'h0, '1);
    give_verdict();
  end
endmodule
`default_nettype wire
